// File: psa_cfg.svh
// constants for the packed integer simd alu
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH
`define PSA_DATA_W      64
`define PSA_OP_W        6
`define PSA_REGS        8
`define PSA_RESULT_RST  64'h0000_0000_0000_0000
`define PSA_FEATURE_ON  1'b1
`endif

// File: psa_pkg.sv
// types for the packed integer simd alu
package psa_pkg;
  typedef enum logic [5:0] {
    OP_MOVE_DWORD = 6'h00, OP_MOVE_QWORD = 6'h01,
    OP_NARROW_W_B_SSAT = 6'h02, OP_NARROW_D_W_SSAT = 6'h03, OP_NARROW_W_B_USAT = 6'h04,
    OP_ILV_HIGH_B = 6'h05, OP_ILV_HIGH_W = 6'h06, OP_ILV_HIGH_D = 6'h07,
    OP_ILV_LOW_B = 6'h08, OP_ILV_LOW_W = 6'h09, OP_ILV_LOW_D = 6'h0a,
    OP_ADD_B = 6'h0b, OP_ADD_W = 6'h0c, OP_ADD_D = 6'h0d,
    OP_ADD_B_SSAT = 6'h0e, OP_ADD_W_SSAT = 6'h0f, OP_ADD_B_USAT = 6'h10, OP_ADD_W_USAT = 6'h11,
    OP_SUB_B = 6'h12, OP_SUB_W = 6'h13, OP_SUB_D = 6'h14,
    OP_SUB_B_SSAT = 6'h15, OP_SUB_W_SSAT = 6'h16, OP_SUB_B_USAT = 6'h17, OP_SUB_W_USAT = 6'h18,
    OP_MUL_HIGH = 6'h19, OP_MUL_LOW = 6'h1a, OP_MUL_PAIR_ADD = 6'h1b,
    OP_CMP_EQ_B = 6'h1c, OP_CMP_EQ_W = 6'h1d, OP_CMP_EQ_D = 6'h1e,
    OP_CMP_GT_B = 6'h1f, OP_CMP_GT_W = 6'h20, OP_CMP_GT_D = 6'h21,
    OP_AND = 6'h22, OP_ANDNOT = 6'h23, OP_OR = 6'h24, OP_XOR = 6'h25,
    OP_SHL_W = 6'h26, OP_SHL_D = 6'h27, OP_SHL_Q = 6'h28,
    OP_SHR_W = 6'h29, OP_SHR_D = 6'h2a, OP_SHR_Q = 6'h2b,
    OP_SAR_W = 6'h2c, OP_SAR_D = 6'h2d
  } psa_op_e;
  typedef enum logic [1:0] {
    SRC_PACKED = 2'b00, SRC_MEMORY = 2'b01, SRC_GENERAL = 2'b10
  } psa_src_e;
  typedef struct packed {
    logic     valid;
    psa_op_e  op;
    psa_src_e srcSel;
    logic [2:0] dstReg;
    logic [2:0] srcAReg;
    logic [2:0] srcBReg;
  } psa_req_s;
  typedef struct packed {
    logic        valid;
    logic [2:0]  dstReg;
    logic [63:0] data;
  } psa_res_s;
endpackage

// File: psa_alu.sv
// packed integer simd alu datapath with its packed register file
`timescale 1ns/1ps
`include "psa_cfg.svh"

// Function
// - operands are packed lanes; sources from packed regs, memory or general regs
// - dword and qword moves pass values unchanged
// - pack narrows with signed or unsigned saturation, clamping lanes
// - unpack interleaves high or low lanes of both sources
// - wrapping add and subtract per lane, no carry between lanes
// - signed saturating byte and word add and subtract clamp to signed limits
// - unsigned saturating byte and word add and subtract clamp to ones or zero
// - high multiply keeps upper half of signed word products
// - low multiply keeps lower half of signed word products
// - multiply-add sums adjacent word products into doublewords
// - equality compare per byte, word or dword lane
// - signed greater-than compare per lane, first operand against second
// - bitwise and, andnot of first operand, or, xor over quadword
// - logical left shift of word, dword, qword lanes, zero fill
// - logical right shift of word, dword, qword lanes, zero fill
// - arithmetic right shift for word and dword lanes only, sign fill
// - every shift acts on a 64-bit operand split into lanes
// - support reported by identification; ops refused when not supported
// - state clear empties the packed register state
module psa_alu #(
  parameter int DATA_W = `PSA_DATA_W,
  parameter int REGS   = `PSA_REGS
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // decoder request
  input  wire psa_pkg::psa_req_s reqIn,
  input  wire logic [63:0]       memData,
  input  wire logic [63:0]       gprData,
  input  wire logic [63:0]       shiftCount,
  input  wire logic              stateClear,
  // identification and result
  output logic                   featureSupported,
  output logic                   illegalOp,
  output psa_pkg::psa_res_s      resOut
);

  // packed register file, cleared by reset or state clear
  logic [DATA_W-1:0] regFile_r [REGS];
  psa_pkg::psa_res_s resOut_r;
  logic              illegalOp_r;

  // lane helpers
  function automatic logic [7:0] satSB(input logic signed [9:0] v);
    satSB = (v > 10'sd127) ? 8'h7f : (v < -10'sd128) ? 8'h80 : v[7:0];
  endfunction
  function automatic logic [15:0] satSW(input logic signed [17:0] v);
    satSW = (v > 18'sd32767) ? 16'h7fff : (v < -18'sd32768) ? 16'h8000 : v[15:0];
  endfunction
  function automatic logic [7:0] satUB(input logic signed [9:0] v);
    satUB = (v > 10'sd255) ? 8'hff : (v < 10'sd0) ? 8'h00 : v[7:0];
  endfunction
  function automatic logic [15:0] satUW(input logic signed [17:0] v);
    satUW = (v > 18'sd65535) ? 16'hffff : (v < 18'sd0) ? 16'h0000 : v[15:0];
  endfunction

  // lane widening ahead of the saturators; two guard bits keep sums and differences exact
  function automatic logic signed [9:0] sxB(input logic [7:0] b);
    sxB = 10'(signed'(b));
  endfunction
  function automatic logic signed [9:0] zxB(input logic [7:0] b);
    zxB = signed'({2'b00, b});
  endfunction
  function automatic logic signed [17:0] sxW(input logic [15:0] w);
    sxW = 18'(signed'(w));
  endfunction
  function automatic logic signed [17:0] zxW(input logic [15:0] w);
    zxW = signed'({2'b00, w});
  endfunction

  // a signed word squeezed into the ten-bit range the byte saturators take;
  // values past that range saturate the same way, so the clamp loses nothing
  function automatic logic signed [9:0] clampW10(input logic [15:0] w);
    logic signed [15:0] s;
    s = signed'(w);
    if (s > 16'sh01ff) begin
      clampW10 = 10'sh1ff;
    end else if (s < 16'shfe00) begin
      clampW10 = 10'sh200;
    end else begin
      clampW10 = s[9:0];
    end
  endfunction

  // word to byte narrowing, signed and unsigned targets
  function automatic logic [7:0] narSB(input logic [15:0] w);
    narSB = satSB(clampW10(w));
  endfunction
  function automatic logic [7:0] narUB(input logic [15:0] w);
    narUB = satUB(clampW10(w));
  endfunction

  // dword to signed word narrowing
  function automatic logic [15:0] narSW(input logic [31:0] d);
    logic signed [31:0] s;
    s = signed'(d);
    if (s > 32'sh0000_7fff) begin
      narSW = 16'h7fff;
    end else if (s < 32'shffff_8000) begin
      narSW = 16'h8000;
    end else begin
      narSW = d[15:0];
    end
  endfunction

  // operand selection: a from packed reg, b from the chosen source
  wire logic [63:0] opA = regFile_r[reqIn.srcAReg];
  wire logic [63:0] opB = (reqIn.srcSel == psa_pkg::SRC_MEMORY)  ? memData :
                          (reqIn.srcSel == psa_pkg::SRC_GENERAL) ? gprData :
                          regFile_r[reqIn.srcBReg];
  wire logic        cntBig = |shiftCount[63:6];
  wire logic [6:0]  cnt    = {1'b0, shiftCount[5:0]};
  // counts past a lane's width; the whole 64-bit count is looked at, so a
  // huge count with small low bits still empties a logical-shift lane and sign-fills an arithmetic one
  wire logic        ovW    = cntBig || (cnt > 7'd15);
  wire logic        ovD    = cntBig || (cnt > 7'd31);

  // lane-wise results
  logic [63:0] rAddB, rAddW, rAddD, rSubB, rSubW, rSubD;
  logic [63:0] rAddBS, rAddWS, rAddBU, rAddWU, rSubBS, rSubWS, rSubBU, rSubWU;
  logic [63:0] rEqB, rEqW, rEqD, rGtB, rGtW, rGtD;
  logic [63:0] rMulH, rMulL, rMadd, rPkSB, rPkSW, rPkUB;
  logic [63:0] rShlW, rShlD, rShrW, rShrD, rSarW, rSarD, rShlQ, rShrQ;
  logic [63:0] rIlHB, rIlHW, rIlHD, rIlLB, rIlLW, rIlLD;

  // byte lanes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rAddB[8*i+:8]  = 8'(opA[8*i+:8] + opB[8*i+:8]);
      rSubB[8*i+:8]  = 8'(opA[8*i+:8] - opB[8*i+:8]);
      rAddBS[8*i+:8] = satSB(sxB(opA[8*i+:8]) + sxB(opB[8*i+:8]));
      rSubBS[8*i+:8] = satSB(sxB(opA[8*i+:8]) - sxB(opB[8*i+:8]));
      rAddBU[8*i+:8] = satUB(zxB(opA[8*i+:8]) + zxB(opB[8*i+:8]));
      rSubBU[8*i+:8] = satUB(zxB(opA[8*i+:8]) - zxB(opB[8*i+:8]));
      rEqB[8*i+:8]   = {8{opA[8*i+:8] == opB[8*i+:8]}};
      rGtB[8*i+:8]   = {8{signed'(opA[8*i+:8]) > signed'(opB[8*i+:8])}};
    end
  end

  // word lanes
  always_comb begin
    logic signed [31:0] prod;
    prod = '0;
    for (int i = 0; i < 4; i++) begin
      rAddW[16*i+:16]  = 16'(opA[16*i+:16] + opB[16*i+:16]);
      rSubW[16*i+:16]  = 16'(opA[16*i+:16] - opB[16*i+:16]);
      rAddWS[16*i+:16] = satSW(sxW(opA[16*i+:16]) + sxW(opB[16*i+:16]));
      rSubWS[16*i+:16] = satSW(sxW(opA[16*i+:16]) - sxW(opB[16*i+:16]));
      rAddWU[16*i+:16] = satUW(zxW(opA[16*i+:16]) + zxW(opB[16*i+:16]));
      rSubWU[16*i+:16] = satUW(zxW(opA[16*i+:16]) - zxW(opB[16*i+:16]));
      rEqW[16*i+:16]   = {16{opA[16*i+:16] == opB[16*i+:16]}};
      rGtW[16*i+:16]   = {16{signed'(opA[16*i+:16]) > signed'(opB[16*i+:16])}};
      prod = signed'(opA[16*i+:16]) * signed'(opB[16*i+:16]);
      rMulH[16*i+:16]  = prod[31:16];
      rMulL[16*i+:16]  = prod[15:0];
      rShlW[16*i+:16]  = ovW ? 16'h0000 : 16'(opA[16*i+:16] << cnt);
      rShrW[16*i+:16]  = ovW ? 16'h0000 : 16'(opA[16*i+:16] >> cnt);
      rSarW[16*i+:16]  = ovW ? {16{opA[16*i+15]}} :
                         16'(signed'(opA[16*i+:16]) >>> cnt);
      // each word lane is a signed word source narrowed to a signed or unsigned byte
      rPkSB[8*i+:8]    = narSB(opA[16*i+:16]);
      rPkSB[32+8*i+:8] = narSB(opB[16*i+:16]);
      rPkUB[8*i+:8]    = narUB(opA[16*i+:16]);
      rPkUB[32+8*i+:8] = narUB(opB[16*i+:16]);
    end
  end

  // dword lanes
  always_comb begin
    logic signed [32:0] madd;
    madd = '0;
    for (int i = 0; i < 2; i++) begin
      rAddD[32*i+:32] = 32'(opA[32*i+:32] + opB[32*i+:32]);
      rSubD[32*i+:32] = 32'(opA[32*i+:32] - opB[32*i+:32]);
      rEqD[32*i+:32]  = {32{opA[32*i+:32] == opB[32*i+:32]}};
      rGtD[32*i+:32]  = {32{signed'(opA[32*i+:32]) > signed'(opB[32*i+:32])}};
      madd = 33'(signed'(opA[32*i+:16]) * signed'(opB[32*i+:16]))
           + 33'(signed'(opA[32*i+16+:16]) * signed'(opB[32*i+16+:16]));
      rMadd[32*i+:32] = madd[31:0];
      rShlD[32*i+:32] = ovD ? 32'h0000_0000 : 32'(opA[32*i+:32] << cnt);
      rShrD[32*i+:32] = ovD ? 32'h0000_0000 : 32'(opA[32*i+:32] >> cnt);
      rSarD[32*i+:32] = ovD ? {32{opA[32*i+31]}} :
                        32'(signed'(opA[32*i+:32]) >>> cnt);
      // signed dword to signed word narrowing
      rPkSW[16*i+:16]    = narSW(opA[32*i+:32]);
      rPkSW[32+16*i+:16] = narSW(opB[32*i+:32]);
    end
  end

  // quadword shifts and interleaves
  assign rShlQ = cntBig ? 64'h0000_0000_0000_0000 : opA << cnt[5:0];
  assign rShrQ = cntBig ? 64'h0000_0000_0000_0000 : opA >> cnt[5:0];
  assign rIlHB = {opB[63:56], opA[63:56], opB[55:48], opA[55:48],
                  opB[47:40], opA[47:40], opB[39:32], opA[39:32]};
  assign rIlHW = {opB[63:48], opA[63:48], opB[47:32], opA[47:32]};
  assign rIlHD = {opB[63:32], opA[63:32]};
  assign rIlLB = {opB[31:24], opA[31:24], opB[23:16], opA[23:16],
                  opB[15:8], opA[15:8], opB[7:0], opA[7:0]};
  assign rIlLW = {opB[31:16], opA[31:16], opB[15:0], opA[15:0]};
  assign rIlLD = {opB[31:0], opA[31:0]};

  // result selection
  logic [63:0] result;
  always_comb begin
    unique case (reqIn.op)
      // moves and narrowing
      psa_pkg::OP_MOVE_DWORD:      result = {32'h0000_0000, opB[31:0]};
      psa_pkg::OP_MOVE_QWORD:      result = opB;
      psa_pkg::OP_NARROW_W_B_SSAT: result = rPkSB;
      psa_pkg::OP_NARROW_D_W_SSAT: result = rPkSW;
      psa_pkg::OP_NARROW_W_B_USAT: result = rPkUB;
      // interleaves, low lane always from a
      psa_pkg::OP_ILV_HIGH_B:      result = rIlHB;
      psa_pkg::OP_ILV_HIGH_W:      result = rIlHW;
      psa_pkg::OP_ILV_HIGH_D:      result = rIlHD;
      psa_pkg::OP_ILV_LOW_B:       result = rIlLB;
      psa_pkg::OP_ILV_LOW_W:       result = rIlLW;
      psa_pkg::OP_ILV_LOW_D:       result = rIlLD;
      // wrapping add
      psa_pkg::OP_ADD_B:           result = rAddB;
      psa_pkg::OP_ADD_W:           result = rAddW;
      psa_pkg::OP_ADD_D:           result = rAddD;
      // saturating add
      psa_pkg::OP_ADD_B_SSAT:      result = rAddBS;
      psa_pkg::OP_ADD_W_SSAT:      result = rAddWS;
      psa_pkg::OP_ADD_B_USAT:      result = rAddBU;
      psa_pkg::OP_ADD_W_USAT:      result = rAddWU;
      // wrapping and saturating subtract
      psa_pkg::OP_SUB_B:           result = rSubB;
      psa_pkg::OP_SUB_W:           result = rSubW;
      psa_pkg::OP_SUB_D:           result = rSubD;
      psa_pkg::OP_SUB_B_SSAT:      result = rSubBS;
      psa_pkg::OP_SUB_W_SSAT:      result = rSubWS;
      psa_pkg::OP_SUB_B_USAT:      result = rSubBU;
      psa_pkg::OP_SUB_W_USAT:      result = rSubWU;
      // multiplies
      psa_pkg::OP_MUL_HIGH:        result = rMulH;
      psa_pkg::OP_MUL_LOW:         result = rMulL;
      psa_pkg::OP_MUL_PAIR_ADD:    result = rMadd;
      // compares give lane masks
      psa_pkg::OP_CMP_EQ_B:        result = rEqB;
      psa_pkg::OP_CMP_EQ_W:        result = rEqW;
      psa_pkg::OP_CMP_EQ_D:        result = rEqD;
      psa_pkg::OP_CMP_GT_B:        result = rGtB;
      psa_pkg::OP_CMP_GT_W:        result = rGtW;
      psa_pkg::OP_CMP_GT_D:        result = rGtD;
      // bitwise logic over the whole quadword
      psa_pkg::OP_AND:             result = opA & opB;
      psa_pkg::OP_ANDNOT:          result = ~opA & opB;
      psa_pkg::OP_OR:              result = opA | opB;
      psa_pkg::OP_XOR:             result = opA ^ opB;
      // shifts, count from the dedicated count input
      psa_pkg::OP_SHL_W:           result = rShlW;
      psa_pkg::OP_SHL_D:           result = rShlD;
      psa_pkg::OP_SHL_Q:           result = rShlQ;
      psa_pkg::OP_SHR_W:           result = rShrW;
      psa_pkg::OP_SHR_D:           result = rShrD;
      psa_pkg::OP_SHR_Q:           result = rShrQ;
      psa_pkg::OP_SAR_W:           result = rSarW;
      psa_pkg::OP_SAR_D:           result = rSarD;
      default:                     result = `PSA_RESULT_RST; // undefined codes yield zero
    endcase
  end

  // legal codes only, and only while the feature is present;
  // a refused request leaves the register file untouched
  // legal codes only, and only while the feature is present
  wire logic opKnown = (reqIn.op <= psa_pkg::OP_SAR_D);
  wire logic doExec  = reqIn.valid && opKnown && featureSupported;
  assign featureSupported = `PSA_FEATURE_ON;

  // one request per cycle: the write lands on the edge that takes the request,
  // so a dependent request may follow back to back with no bypass path;
  // the price is that the whole lane datapath sits in one clock period
  // register file write and clear; clear wins over a same-cycle write to empty state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REGS; i++) regFile_r[i] <= `PSA_RESULT_RST;
    end else if (stateClear) begin
      for (int i = 0; i < REGS; i++) regFile_r[i] <= `PSA_RESULT_RST;
    end else if (doExec) begin
      regFile_r[reqIn.dstReg] <= result;
    end
  end

  // registered result and refusal flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resOut_r    <= '0;
      illegalOp_r <= 1'b0;
    end else begin
      resOut_r    <= '{valid: doExec && !stateClear, dstReg: reqIn.dstReg, data: result};
      illegalOp_r <= reqIn.valid && !(opKnown && featureSupported);
    end
  end

  assign resOut    = resOut_r;
  assign illegalOp = illegalOp_r;

endmodule // psa_alu

// File: psa_alu_assertions.sv
// concurrent checks on the packed simd alu ports
`timescale 1ns/1ps
module psa_alu_assertions (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  // request side
  input wire psa_pkg::psa_req_s reqIn,
  input wire logic [63:0]       memData,
  input wire logic [63:0]       gprData,
  input wire logic [63:0]       shiftCount,
  input wire logic              stateClear,
  // answer side
  input wire logic              featureSupported,
  input wire logic              illegalOp,
  input wire psa_pkg::psa_res_s resOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // decode of what the alu should take and what it must refuse
  wire badReq   = reqIn.valid && reqIn.op > psa_pkg::OP_SAR_D;
  wire legalReq = reqIn.valid && reqIn.op <= psa_pkg::OP_SAR_D && !stateClear;
  wire orZero   = reqIn.op == psa_pkg::OP_OR && reqIn.srcSel == psa_pkg::SRC_MEMORY && memData == 64'h0000_0000_0000_0000;
  // a clear followed by an or with zero exposes the cleared register
  sequence clearThenRead;
    stateClear ##1 (legalReq && orZero);
  endsequence
  a_feature_on: assert property (featureSupported == 1'b1)
    else $error("support report low");
  a_issue_answers: assert property (legalReq |=> resOut.valid && resOut.dstReg == $past(reqIn.dstReg))
    else $error("legal request gave no result");
  a_no_stray_result: assert property (!legalReq |=> !resOut.valid)
    else $error("result without request");
  a_bad_op_flag: assert property (badReq |=> illegalOp && !resOut.valid)
    else $error("unknown op not refused");
  a_flag_only_bad: assert property (!badReq |=> !illegalOp)
    else $error("refusal without cause");
  a_qword_move: assert property (legalReq && reqIn.op == psa_pkg::OP_MOVE_QWORD
    && reqIn.srcSel == psa_pkg::SRC_MEMORY |=> resOut.data == $past(memData))
    else $error("qword move altered data");
  a_dword_zero_ext: assert property (legalReq && reqIn.op == psa_pkg::OP_MOVE_DWORD && reqIn.srcSel ==
    psa_pkg::SRC_GENERAL |=> resOut.data == ($past(gprData) & 64'h0000_0000_ffff_ffff))
    else $error("dword move not zero extended");
  a_clear_blocks: assert property (stateClear |=> !resOut.valid)
    else $error("result during clear");
  a_clear_empties: assert property (clearThenRead |=> resOut.data == 64'h0000_0000_0000_0000)
    else $error("register survived clear");
  a_shift_oversize: assert property (legalReq && reqIn.op == psa_pkg::OP_SHL_Q
    && shiftCount >= 64'h0000_0000_0000_0040 |=> resOut.data == 64'h0000_0000_0000_0000)
    else $error("oversize shift not zero");
endmodule // psa_alu_assertions

bind psa_alu psa_alu_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn), .reqIn(reqIn), .memData(memData),
  .gprData(gprData), .shiftCount(shiftCount), .stateClear(stateClear), .featureSupported(featureSupported),
  .illegalOp(illegalOp), .resOut(resOut));

// File: psa_operand_src.sv
// memory operand source model on the far side of the alu
`timescale 1ns/1ps
module psa_operand_src (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // request seen and value offered
  input  wire psa_pkg::psa_req_s reqIn,
  input  wire logic [63:0]       memVal,
  // operand to the alu
  output logic [63:0]            memData
);
  logic [63:0] lastMem_r;
  wire         memSel = reqIn.valid && reqIn.srcSel == psa_pkg::SRC_MEMORY;
  // unselected bus shows the inverse of the last value so stale data cannot pass
  assign memData = memSel ? memVal : ~lastMem_r;
  // remember the last value handed over
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) lastMem_r <= '0;
    else if (memSel) lastMem_r <= memVal;
  end
endmodule // psa_operand_src

// File: psa_alu_bench.sv
// self-checking bench for the packed simd alu
`timescale 1ns/1ps
module psa_alu_bench;
  logic              clk_sys = 1'b0;
  logic              resetn = 1'b0;
  psa_pkg::psa_req_s reqIn = '0;
  logic [63:0]       memVal = '0;
  logic [63:0]       gprData = '0;
  logic [63:0]       shiftCount = '0;
  logic              stateClear = 1'b0;
  logic [63:0]       memData;
  logic              featureSupported;
  logic              illegalOp;
  psa_pkg::psa_res_s resOut;
  logic [63:0]       shadow [8] = '{default: '0};
  logic [67:0]       expQ [$];
  int                err_count = 0;
  int                tests_run = 0;
  int wTab [46] = '{32, 64, 16, 32, 16, 8, 16, 32, 8, 16, 32, 8, 16, 32, 8, 16, 8, 16, 8, 16, 32, 8, 16, 8, 16,
    16, 16, 32, 8, 16, 32, 8, 16, 32, 64, 64, 64, 64, 16, 32, 64, 16, 32, 64, 16, 32};
  logic [63:0] bnd [4] = '{64'h7fff_8000_7f80_ff01, 64'h8000_7fff_0180_80ff, 64'hffff_ffff_0000_0000,
    64'h8000_0000_7fff_ffff};

  psa_alu dut (.clk_sys(clk_sys), .resetn(resetn), .reqIn(reqIn), .memData(memData), .gprData(gprData),
    .shiftCount(shiftCount), .stateClear(stateClear), .featureSupported(featureSupported),
    .illegalOp(illegalOp), .resOut(resOut));
  psa_operand_src u_src (.clk_sys(clk_sys), .resetn(resetn), .reqIn(reqIn), .memVal(memVal), .memData(memData));

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [63:0] msk(input int w);
    return (w == 64) ? '1 : (64'h1 << w) - 1;
  endfunction
  // one lane of x, signed or unsigned
  function automatic longint ln(input logic [63:0] x, input int i, input int w, input bit s);
    logic [63:0] u;
    u = (x >> (i * w)) & msk(w);
    return (s && w < 64 && u[w-1]) ? longint'(u) - longint'(64'h1 << w) : longint'(u);
  endfunction
  function automatic longint sat(input longint v, input longint lo, input longint hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  // expected result worked out lane by lane
  function automatic logic [63:0] refOp(input int c, input logic [63:0] a, input logic [63:0] b, input logic [63:0] sh);
    int w, n, h, ow;
    longint x, y, v, mx, lo, hi;
    logic [63:0] r;
    w = wTab[c]; n = 64 / w; h = w / 2; r = '0; v = 0;
    mx = (longint'(1) <<< (w - 1)) - 1;
    ow = (c >= 2 && c <= 4) ? h : w;
    case (c)
      0: return {32'h0000_0000, b[31:0]};
      1: return b;
      34: return a & b;
      35: return ~a & b;
      36: return a | b;
      37: return a ^ b;
      default: ;
    endcase
    for (int i = 0; i < n; i++) begin
      x = ln(a, i, w, 1);
      y = ln(b, i, w, 1);
      case (c) inside
        [5:10]: v = ln((i % 2) ? b : a, ((c < 8) ? n / 2 : 0) + i / 2, w, 0);
        [11:13]: v = x + y;
        [14:15]: v = sat(x + y, -mx - 1, mx);
        [16:17]: v = sat(ln(a, i, w, 0) + ln(b, i, w, 0), 0, 2 * mx + 1);
        [18:20]: v = x - y;
        [21:22]: v = sat(x - y, -mx - 1, mx);
        [23:24]: v = sat(ln(a, i, w, 0) - ln(b, i, w, 0), 0, 2 * mx + 1);
        25: v = (x * y) >>> 16;
        26: v = x * y;
        27: v = ln(a, 2 * i, 16, 1) * ln(b, 2 * i, 16, 1) + ln(a, 2 * i + 1, 16, 1) * ln(b, 2 * i + 1, 16, 1);
        [28:30]: v = (x == y) ? -1 : 0;
        [31:33]: v = (x > y) ? -1 : 0;
        [38:40]: v = (sh >= w) ? 0 : ln(a, i, w, 0) << sh;
        [41:43]: v = (sh >= w) ? 0 : ln(a, i, w, 0) >> sh;
        [44:45]: v = (sh >= w) ? ((x < 0) ? -1 : 0) : x >>> sh;
        default: begin
          hi = (c == 4) ? 255 : (longint'(1) <<< (h - 1)) - 1;
          lo = (c == 4) ? 0 : -hi - 1;
          r |= (64'(sat(y, lo, hi)) & msk(h)) << ((i + n) * h);
          v = sat(x, lo, hi);
        end
      endcase
      r |= (64'(v) & msk(ow)) << (i * ow);
    end
    return r;
  endfunction

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one request; the expectation is noted before the edge that takes it
  task automatic issue(input int c, input int sel, input int d, input logic [63:0] bv, input logic [63:0] sh,
    input bit clr);
    logic [2:0] ra, rb;
    logic [63:0] bb;
    ra = 3'($urandom); rb = 3'($urandom);
    bb = (sel == 0) ? shadow[rb] : bv;
    @(posedge clk_sys); #1;
    reqIn = '{1'b1, psa_pkg::psa_op_e'(c[5:0]), psa_pkg::psa_src_e'(sel[1:0]), 3'(d), ra, rb};
    memVal = bv; gprData = (sel == 2) ? bv : ~gprData; shiftCount = sh; stateClear = clr;
    if (clr) shadow = '{default: '0};
    else if (c > 45) expQ.push_back({1'b1, 67'h0});
    else begin
      bb = refOp(c, shadow[ra], bb, sh);
      expQ.push_back({1'b0, 3'(d), bb});
      shadow[3'(d)] = bb;
    end
  endtask

  // results settle after the edge; compare against the oldest note
  always @(negedge clk_sys) if (resetn && (resOut.valid === 1'b1 || illegalOp === 1'b1)) begin
    logic [67:0] e;
    e = (expQ.size() == 0) ? {1'b1, 67'h0} : expQ.pop_front();
    chk("refused", illegalOp, e[67]);
    chk("valid", resOut.valid, !e[67]);
    if (!e[67]) chk("dst", resOut.dstReg, e[66:64]);
    if (!e[67]) chk("data", resOut.data, e[63:0]);
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end

  initial begin
    logic [63:0] bv, sh;
    void'($urandom(32'h47b6_664a));
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b1;
    chk("feature", featureSupported, 64'h1);
    for (int k = 0; k < 8; k++) issue(1, 1, k, (k < 4) ? bnd[k] : {$urandom, $urandom}, 0, 0);
    // every op code, random sources and boundary lanes, back to back
    repeat (8) for (int c = 0; c < 46; c++) begin
      bv = $urandom_range(1) ? bnd[$urandom_range(3)] : {$urandom, $urandom};
      sh = ($urandom_range(3) == 0) ? {$urandom, $urandom} : 64'($urandom_range(70));
      issue(c, $urandom_range(2), $urandom_range(7), bv, sh, 0);
    end
    issue(40, 1, 2, bnd[0], 64, 0);
    issue(44, 1, 3, bnd[1], 16, 0);
    issue(0, 2, 0, bnd[3], 0, 0);
    issue(46, 1, 4, 0, 0, 0);
    issue(63, 1, 5, 0, 0, 0);
    issue(34, 1, 6, '1, 0, 1);
    issue(36, 1, 7, 0, 0, 0);
    issue(36, 0, 1, 0, 0, 0);
    @(posedge clk_sys); #1;
    reqIn.valid = 1'b0;
    stateClear = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("pending", expQ.size(), 0);
    end_sim();
  end
endmodule // psa_alu_bench
